// ==== design/cme_event_logic.sv ====
// event and status logic: code change, monitor events, pool events
module cme_event_logic
	import cme_pkg::*;
(
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire cme_pkg::cme_if_mode_type if_mode_in,
	input wire logic auto_mode_in,
	input wire logic ch1_change_enable_in,
	input wire logic [cme_pkg::CODE_W-1:0] ch0_rx_code_in,
	input wire logic [cme_pkg::CODE_W-1:0] ch1_rx_code_in,
	input wire logic ch0_code_rd_in,
	input wire logic ch1_code_rd_in,
	output logic [cme_pkg::CODE_W-1:0] ch0_code_reg_out,
	output logic [cme_pkg::CODE_W-1:0] ch1_code_reg_out,
	output logic ch0_code_changed_out,
	output logic ch1_code_changed_out,
	input wire logic monitor_rx_irq_enable_in,
	input wire logic monitor_ready_bit_control_in,
	input wire logic monitor_irq_enable_in,
	input wire logic monitor_transmit_valid_bit_in,
	input wire logic monitor_byte_strobe_in,
	input wire logic [cme_pkg::BYTE_W-1:0] monitor_rx_byte_in,
	input wire cme_pkg::cme_mon_ev_type monitor_ev_in,
	input wire logic monitor_status_rd_in,
	output logic monitor_receive_ack_bit_out,
	output logic monitor_byte_received_out,
	output logic [2:0] monitor_status_reg_out,
	output logic monitor_rx_valid_out,
	input wire logic monitor_rx_ready_in,
	output logic [cme_pkg::BYTE_W-1:0] monitor_rx_data_out,
	input wire cme_pkg::cme_hdlc_ev_type hdlc_ev_in,
	input wire logic [cme_pkg::CNT_W-1:0] rx_frame_bytes_in,
	input wire logic [7:0] command_register_in,
	input wire logic command_wr_in,
	input wire logic [7:0] mask_in,
	input wire logic main_rd_in,
	input wire logic ext_rd_in,
	output logic [7:0] main_irq_status_out,
	output logic [7:0] extended_irq_status_out,
	output logic [cme_pkg::CNT_W-1:0] rx_byte_count_low_out,
	output logic rx_pool_busy_out,
	output logic irq_n_out
);
	import cme_pkg::*;

	logic [CODE_W-1:0] ch0_last;
	logic [CODE_W-1:0] ch1_last;
	logic [CODE_W-1:0] ch0_pend;
	logic [CODE_W-1:0] ch1_pend;
	logic ch0_pend_v;
	logic ch1_pend_v;
	logic ch0_changed;
	logic ch1_changed;
	logic ch1_hidden;
	logic ch1_active;
	logic new0;
	logic new1;
	logic [7:0] main_pend;
	logic [7:0] ext_stat;
	logic [7:0] next_main_set;
	logic [7:0] next_ext_set;
	logic rx_ack_due;
	logic tx_close_seen;
	logic rx_q_valid;
	logic rx_q_is_end;
	logic [CNT_W-1:0] rx_q_count;
	logic rx_new;
	logic rx_free;
	logic rx_show_new;
	logic rx_release;
	logic mon_in_packet;
	logic mon_byte_flag;
	logic mon_prev_mx;
	logic mon_byte_ev;
	logic fifo_in_ready;
	logic rx_complete;

	// channel 1 only counts in terminal mode of the second variant
	assign ch1_active = (if_mode_in == CME_IF_SECOND_TERMINAL);
	assign new0 = (ch0_rx_code_in != ch0_last);
	assign new1 = ch1_active && (ch1_rx_code_in != ch1_last);
	// several command bits may come in one write
	assign rx_complete = command_wr_in &&
		((command_register_in & CMD_RX_COMPLETE) != 8'h00);

	// ch0 code path: register holds until read, one pending entry behind it
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ch0_code_reg_out <= CODE_RST;
			ch0_last <= CODE_RST;
			ch0_pend <= CODE_RST;
			ch0_pend_v <= 1'b0;
			ch0_changed <= 1'b0;
		end else begin
			if (new0) begin
				ch0_last <= ch0_rx_code_in;
			end
			if (ch0_code_rd_in && ch0_pend_v) begin
				ch0_code_reg_out <= new0 ? ch0_rx_code_in : ch0_pend;
				ch0_pend_v <= 1'b0;
				ch0_changed <= 1'b1;
			end else if (new0 && (!ch0_changed || ch0_code_rd_in)) begin
				// a read in the same cycle frees the register at once
				ch0_code_reg_out <= ch0_rx_code_in;
				ch0_changed <= 1'b1;
			end else if (new0) begin
				ch0_pend <= ch0_rx_code_in;
				ch0_pend_v <= 1'b1;
			end else if (ch0_code_rd_in) begin
				ch0_changed <= 1'b0;
			end
		end
	end

	// ch1 code path, same buffering, visibility gated by its enable
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ch1_code_reg_out <= CODE_RST;
			ch1_last <= CODE_RST;
			ch1_pend <= CODE_RST;
			ch1_pend_v <= 1'b0;
			ch1_changed <= 1'b0;
		end else begin
			if (new1) begin
				ch1_last <= ch1_rx_code_in;
			end
			if (ch0_code_rd_in && ch1_pend_v) begin
				ch1_code_reg_out <= new1 ? ch1_rx_code_in : ch1_pend;
				ch1_pend_v <= 1'b0;
				ch1_changed <= 1'b1;
			end else if (new1 && (!ch1_changed || ch0_code_rd_in)) begin
				ch1_code_reg_out <= ch1_rx_code_in;
				ch1_changed <= 1'b1;
			end else if (new1) begin
				ch1_pend <= ch1_rx_code_in;
				ch1_pend_v <= 1'b1;
			end else if (ch0_code_rd_in) begin
				ch1_changed <= 1'b0;
			end
		end
	end

	// a change seen while disabled is kept and shown once enabled
	assign ch1_hidden = !ch1_change_enable_in;
	assign ch0_code_changed_out = ch0_changed;
	assign ch1_code_changed_out = ch1_changed && !ch1_hidden;

	// monitor byte detection on the 1-to-0 edge of the valid bit
	assign mon_byte_ev = monitor_byte_strobe_in && mon_prev_mx &&
		!monitor_transmit_valid_bit_in;
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mon_prev_mx <= 1'b1;
			mon_in_packet <= 1'b0;
			mon_byte_flag <= 1'b0;
			monitor_receive_ack_bit_out <= 1'b1;
		end else begin
			if (monitor_byte_strobe_in) begin
				mon_prev_mx <= monitor_transmit_valid_bit_in;
			end
			if (monitor_ev_in.end_of_rx || monitor_ev_in.data_abort) begin
				mon_in_packet <= 1'b0;
			end else if (mon_byte_ev) begin
				mon_in_packet <= 1'b1;
			end
			if (mon_byte_ev && monitor_rx_irq_enable_in &&
				(monitor_ready_bit_control_in || !mon_in_packet)) begin
				mon_byte_flag <= 1'b1;
			end else if (monitor_status_rd_in) begin
				mon_byte_flag <= 1'b0;
			end
			// ack bit follows the handshake only under ready-bit control
			if (monitor_ready_bit_control_in && monitor_rx_irq_enable_in) begin
				monitor_receive_ack_bit_out <= !(mon_byte_ev &&
					fifo_in_ready);
			end else begin
				monitor_receive_ack_bit_out <= 1'b1;
			end
		end
	end
	assign monitor_byte_received_out = mon_byte_flag;

	// bytes buffered only when every byte is to be kept; a full fifo
	// drops the ack so the far end repeats the byte
	cme_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_mon_fifo (
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.in_valid_in(mon_byte_ev && monitor_rx_irq_enable_in &&
			monitor_ready_bit_control_in),
		.in_ready_out(fifo_in_ready),
		.in_data_in(monitor_rx_byte_in),
		.out_valid_out(monitor_rx_valid_out),
		.out_ready_in(monitor_rx_ready_in),
		.out_data_out(monitor_rx_data_out)
	);

	// receive pool accounting: one event shown, the next waits for ack
	assign rx_new = hdlc_ev_in.rx_block_ready || hdlc_ev_in.rx_frame_end;
	assign rx_release = rx_complete && rx_ack_due && rx_q_valid;
	assign rx_free = !rx_ack_due || (rx_complete && !rx_q_valid);
	assign rx_show_new = rx_new && rx_free;
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_q_valid <= 1'b0;
			rx_q_is_end <= 1'b0;
			rx_q_count <= '0;
			rx_ack_due <= 1'b0;
			rx_byte_count_low_out <= '0;
		end else begin
			// second pool: one more event may wait behind the shown one
			if (rx_new && !rx_show_new) begin
				rx_q_valid <= 1'b1;
				rx_q_is_end <= hdlc_ev_in.rx_frame_end;
				rx_q_count <= rx_frame_bytes_in;
			end else if (rx_release) begin
				rx_q_valid <= 1'b0;
			end
			if (rx_show_new && hdlc_ev_in.rx_frame_end) begin
				rx_byte_count_low_out <= rx_frame_bytes_in;
			end else if (rx_release && rx_q_is_end) begin
				rx_byte_count_low_out <= rx_q_count;
			end
			if (rx_show_new || rx_release) begin
				rx_ack_due <= 1'b1;
			end else if (rx_complete) begin
				rx_ack_due <= 1'b0;
			end
		end
	end
	assign rx_pool_busy_out = rx_ack_due;

	// transmit close tracking for the underrun check
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_close_seen <= 1'b0;
		end else if (command_wr_in &&
			(command_register_in == CMD_TX_I_CLOSE ||
			command_register_in == CMD_TX_TRANSP_CLOSE)) begin
			tx_close_seen <= 1'b1;
		end else if (command_wr_in &&
			(command_register_in == CMD_TX_I_FRAME ||
			command_register_in == CMD_TX_TRANSP ||
			command_register_in == CMD_TX_RESET)) begin
			tx_close_seen <= 1'b0;
		end
	end

	// event set vectors
	always_comb begin
		next_main_set = '0;
		next_ext_set = '0;
		next_main_set[MS_RPF] = (rx_show_new &&
			hdlc_ev_in.rx_block_ready) ||
			(rx_release && !rx_q_is_end);
		next_main_set[MS_RME] = (rx_show_new &&
			hdlc_ev_in.rx_frame_end) ||
			(rx_release && rx_q_is_end);
		next_main_set[MS_XPR] = hdlc_ev_in.tx_space ||
			(auto_mode_in && hdlc_ev_in.tx_acked);
		next_main_set[MS_MOS] = (if_mode_in == CME_IF_FIRST_GEN) ?
			mon_byte_ev :
			(monitor_irq_enable_in && (monitor_ev_in.end_of_rx ||
			monitor_ev_in.data_acked || monitor_ev_in.data_abort)) ||
			(mon_byte_ev && monitor_rx_irq_enable_in &&
			(monitor_ready_bit_control_in || !mon_in_packet));
		next_ext_set[XS_RFO] = hdlc_ev_in.rx_frame_lost;
		next_ext_set[XS_PCE] = auto_mode_in &&
			hdlc_ev_in.protocol_error;
		next_ext_set[XS_XMR] = hdlc_ev_in.tx_error ||
			(auto_mode_in && hdlc_ev_in.tx_nak);
		next_ext_set[XS_XDU] = hdlc_ev_in.tx_pool_empty &&
			!tx_close_seen;
	end

	// monitor status: set wins over read clear
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			monitor_status_reg_out <= '0;
		end else if (if_mode_in != CME_IF_FIRST_GEN) begin
			monitor_status_reg_out <= ((monitor_status_rd_in) ? 3'b000 :
				monitor_status_reg_out) | ({3{monitor_irq_enable_in}} &
				{monitor_ev_in.end_of_rx, monitor_ev_in.data_acked,
				monitor_ev_in.data_abort});
		end else begin
			monitor_status_reg_out <= '0;
		end
	end

	// extended status: read clears, new events win
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ext_stat <= EXT_RST;
		end else begin
			ext_stat <= (ext_rd_in ? 8'h00 : ext_stat) | next_ext_set;
		end
	end
	assign extended_irq_status_out = ext_stat;

	// main pending bits; masked ones survive the read
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			main_pend <= MAIN_RST;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (next_main_set[i]) begin
					main_pend[i] <= 1'b1;
				end else if (main_rd_in && !mask_in[i] &&
					i != MS_EXI && i != MS_CIC) begin
					main_pend[i] <= 1'b0;
				end
			end
			main_pend[MS_EXI] <= 1'b0;
			main_pend[MS_CIC] <= 1'b0;
		end
	end

	always_comb begin
		main_irq_status_out = main_pend & ~mask_in;
		main_irq_status_out[MS_CIC] = ch0_code_changed_out ||
			ch1_code_changed_out;
		main_irq_status_out[MS_EXI] = (ext_stat != 8'h00);
	end
	// summaries set under mask but raise no request
	assign irq_n_out = !((main_irq_status_out & ~mask_in) != 8'h00);
endmodule // cme_event_logic

// ==== design/cme_fifo.sv ====
// small valid/ready fifo used for received monitor bytes
module cme_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem[rd_ptr];
	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // cme_fifo

// ==== design/cme_pkg.sv ====
// package: constants and carriers for the code/monitor/pool event logic
package cme_pkg;
	localparam int CODE_W = 4;
	localparam int BYTE_W = 8;
	localparam int POOL_BYTES = 32;
	localparam int POOL_COUNT = 2;
	localparam int CNT_W = 5;
	localparam int FIFO_DEPTH = 4;
	localparam logic [7:0] CMD_RX_COMPLETE = 8'h80;
	localparam logic [7:0] CMD_TX_RESET = 8'h01;
	localparam logic [7:0] CMD_TX_I_FRAME = 8'h04;
	localparam logic [7:0] CMD_TX_I_CLOSE = 8'h06;
	localparam logic [7:0] CMD_TX_TRANSP = 8'h08;
	localparam logic [7:0] CMD_TX_TRANSP_CLOSE = 8'h0a;
	localparam logic [CODE_W-1:0] CODE_RST = 4'hf;
	localparam logic [7:0] MAIN_RST = 8'h00;
	localparam logic [7:0] EXT_RST = 8'h00;
	// main status bit positions
	localparam int MS_RPF = 7;
	localparam int MS_RME = 6;
	localparam int MS_XPR = 4;
	localparam int MS_CIC = 2;
	localparam int MS_MOS = 1;
	localparam int MS_EXI = 0;
	// extended status bit positions
	localparam int XS_XMR = 7;
	localparam int XS_XDU = 6;
	localparam int XS_PCE = 5;
	localparam int XS_RFO = 4;
	typedef enum logic [1:0] {
		CME_IF_FIRST_GEN,
		CME_IF_SECOND_TERMINAL,
		CME_IF_SECOND_NONTERM
	} cme_if_mode_type;
	typedef struct packed {
		logic rx_block_ready;
		logic rx_frame_end;
		logic rx_frame_lost;
		logic protocol_error;
		logic tx_space;
		logic tx_acked;
		logic tx_error;
		logic tx_nak;
		logic tx_pool_empty;
	} cme_hdlc_ev_type;
	typedef struct packed {
		logic end_of_rx;
		logic data_acked;
		logic data_abort;
	} cme_mon_ev_type;
endpackage

// ==== verif/cme_event_logic_asserts.sv ====
// checker: timing relations on the event logic ports
module cme_event_logic_asserts
	import cme_pkg::*;
(
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic auto_mode_in,
	input wire logic ch1_change_enable_in,
	input wire logic ch0_code_rd_in,
	input wire logic [cme_pkg::CODE_W-1:0] ch0_code_reg_out,
	input wire logic [cme_pkg::CODE_W-1:0] ch1_code_reg_out,
	input wire logic ch0_code_changed_out,
	input wire logic ch1_code_changed_out,
	input wire logic monitor_rx_irq_enable_in,
	input wire logic monitor_irq_enable_in,
	input wire logic monitor_byte_received_out,
	input wire logic [2:0] monitor_status_reg_out,
	input wire cme_pkg::cme_hdlc_ev_type hdlc_ev_in,
	input wire logic [cme_pkg::CNT_W-1:0] rx_frame_bytes_in,
	input wire logic [7:0] main_irq_status_out,
	input wire logic [7:0] extended_irq_status_out,
	input wire logic [cme_pkg::CNT_W-1:0] rx_byte_count_low_out,
	input wire logic rx_pool_busy_out,
	input wire logic irq_n_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);
	// a read lands at the edge after it is sampled
	sequence s_code_read;
		ch0_code_rd_in ##1 1'b1;
	endsequence
	sequence s_frame_done;
		hdlc_ev_in.rx_frame_end && !rx_pool_busy_out;
	endsequence
	a_code_change_flag: assert property ($changed(ch0_code_reg_out)
		|-> ch0_code_changed_out) else $error("code moved without flag");
	a_code_held: assert property (ch0_code_changed_out
		&& !ch0_code_rd_in |=> $stable(ch0_code_reg_out))
		else $error("code replaced before read");
	a_read_clears: assert property (s_code_read |->
		(!ch0_code_changed_out || $changed(ch0_code_reg_out)) &&
		(!ch1_code_changed_out || $changed(ch1_code_reg_out)))
		else $error("change bits survive read");
	a_ch1_gate: assert property (!ch1_change_enable_in
		|-> !ch1_code_changed_out) else $error("ch1 change shown");
	a_mon_rx_gate: assert property (!monitor_rx_irq_enable_in &&
		!monitor_byte_received_out |=> !monitor_byte_received_out)
		else $error("byte flag without enable");
	a_mon_ev_gate: assert property (!monitor_irq_enable_in &&
		monitor_status_reg_out == 3'b000 |=> monitor_status_reg_out == 3'b000)
		else $error("monitor event without enable");
	a_frame_count: assert property (s_frame_done |=>
		rx_byte_count_low_out == $past(rx_frame_bytes_in))
		else $error("byte count not taken");
	a_overflow_flag: assert property (hdlc_ev_in.rx_frame_lost
		|=> extended_irq_status_out[XS_RFO]) else $error("overflow lost");
	a_pce_auto_only: assert property (!auto_mode_in &&
		!extended_irq_status_out[XS_PCE] |=> !extended_irq_status_out[XS_PCE])
		else $error("protocol error outside auto");
	a_irq_clear: assert property (main_irq_status_out == 8'h00
		|-> irq_n_out) else $error("irq with status clear");
endmodule // cme_event_logic_asserts
bind cme_event_logic cme_event_logic_asserts i_chk (.mclk_in, .nrst_in,
	.auto_mode_in, .ch1_change_enable_in, .ch0_code_rd_in,
	.ch0_code_reg_out, .ch1_code_reg_out, .ch0_code_changed_out,
	.ch1_code_changed_out, .monitor_rx_irq_enable_in,
	.monitor_irq_enable_in, .monitor_byte_received_out,
	.monitor_status_reg_out, .hdlc_ev_in, .rx_frame_bytes_in,
	.main_irq_status_out, .extended_irq_status_out,
	.rx_byte_count_low_out, .rx_pool_busy_out, .irq_n_out);

// ==== verif/cme_l1_model.sv ====
// far-side model: layer-1 device sending monitor bytes
module cme_l1_model
	import cme_pkg::*;
(
	input wire logic mclk_in,
	output logic strobe_out,
	output logic valid_bit_out,
	output logic [cme_pkg::BYTE_W-1:0] byte_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		strobe_out = 1'b0;
		valid_bit_out = 1'b1;
		byte_out = 8'h00;
	end
	// idle slot with the bit high, then the byte slot with it low
	task automatic send(input logic [7:0] first, input int n);
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 2; k++) begin
				@(negedge mclk_in);
				strobe_out = 1'b1;
				valid_bit_out = (k == 0);
				byte_out = first + 8'(i);
				@(negedge mclk_in);
				strobe_out = 1'b0;
				// data outside a slot is not held: invert it
				byte_out = ~byte_out;
			end
		end
	endtask
endmodule // cme_l1_model

// ==== verif/tb_cme_event_logic.sv ====
// testbench: code buffer, monitor gating and pool events
module tb_cme_event_logic;
	timeunit 1ns;
	timeprecision 1ns;
	import cme_pkg::*;
	typedef struct packed {
		logic [8:0] ev;
		logic [7:0] cmd, main, ext;
	} cme_row_type;
	localparam cme_row_type ROWS[9] = '{
		'{9'h100, 8'h00, 8'h80, 8'h00},
		'{9'h080, 8'h00, 8'h40, 8'h00},
		'{9'h040, 8'h00, 8'h01, 8'h10},
		'{9'h020, 8'h00, 8'h01, 8'h20},
		'{9'h010, 8'h00, 8'h10, 8'h00},
		'{9'h008, CMD_TX_I_CLOSE, 8'h10, 8'h00},
		'{9'h004, 8'h00, 8'h01, 8'h80},
		'{9'h002, 8'h00, 8'h01, 8'h80},
		'{9'h001, CMD_TX_TRANSP, 8'h01, 8'h40}
	};
	logic mclk_in, nrst_in, auto_mode_in, ch1_change_enable_in;
	logic ch0_code_rd_in, ch1_code_rd_in, monitor_rx_irq_enable_in;
	logic monitor_ready_bit_control_in, monitor_irq_enable_in;
	logic monitor_transmit_valid_bit_in, monitor_byte_strobe_in;
	logic monitor_status_rd_in, monitor_rx_ready_in, command_wr_in;
	logic main_rd_in, ext_rd_in, monitor_receive_ack_bit_out;
	logic monitor_byte_received_out, monitor_rx_valid_out;
	logic ch0_code_changed_out, ch1_code_changed_out;
	logic rx_pool_busy_out, irq_n_out;
	logic [CODE_W-1:0] ch0_rx_code_in, ch1_rx_code_in;
	logic [CODE_W-1:0] ch0_code_reg_out, ch1_code_reg_out;
	logic [BYTE_W-1:0] monitor_rx_byte_in, monitor_rx_data_out;
	logic [7:0] command_register_in, mask_in;
	logic [7:0] main_irq_status_out, extended_irq_status_out;
	logic [2:0] monitor_status_reg_out;
	logic [CNT_W-1:0] rx_frame_bytes_in, rx_byte_count_low_out;
	cme_if_mode_type if_mode_in;
	cme_mon_ev_type monitor_ev_in;
	cme_hdlc_ev_type hdlc_ev_in;
	wire [7:0] ms = main_irq_status_out;
	wire [7:0] es = extended_irq_status_out;
	int bad_count = 0;
	int n_tests = 0;
	cme_event_logic i_dut (.mclk_in, .nrst_in, .if_mode_in, .auto_mode_in,
		.ch1_change_enable_in, .ch0_rx_code_in, .ch1_rx_code_in,
		.ch0_code_rd_in, .ch1_code_rd_in, .ch0_code_reg_out,
		.ch1_code_reg_out, .ch0_code_changed_out, .ch1_code_changed_out,
		.monitor_rx_irq_enable_in, .monitor_ready_bit_control_in,
		.monitor_irq_enable_in, .monitor_transmit_valid_bit_in,
		.monitor_byte_strobe_in, .monitor_rx_byte_in, .monitor_ev_in,
		.monitor_status_rd_in, .monitor_receive_ack_bit_out,
		.monitor_byte_received_out, .monitor_status_reg_out,
		.monitor_rx_valid_out, .monitor_rx_ready_in, .monitor_rx_data_out,
		.hdlc_ev_in, .rx_frame_bytes_in, .command_register_in,
		.command_wr_in, .mask_in, .main_rd_in, .ext_rd_in,
		.main_irq_status_out, .extended_irq_status_out,
		.rx_byte_count_low_out, .rx_pool_busy_out, .irq_n_out);
	cme_l1_model i_l1 (.mclk_in, .strobe_out(monitor_byte_strobe_in),
		.valid_bit_out(monitor_transmit_valid_bit_in),
		.byte_out(monitor_rx_byte_in));
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
		tick(1);
	endtask
	task automatic hev(input logic [8:0] e);
		hdlc_ev_in = e;
		tick(1);
		hdlc_ev_in = '0;
	endtask
	task automatic mev;
		monitor_ev_in = '1;
		tick(1);
		monitor_ev_in = '0;
		tick(1);
	endtask
	task automatic cmd_wr(input logic [7:0] c);
		command_register_in = c;
		pulse(command_wr_in);
	endtask
	task automatic do_reset;
		nrst_in = 1'b0;
		tick(12);
		nrst_in = 1'b1;
		tick(1);
	endtask
	task automatic chk(input string n, input logic [7:0] s, e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge mclk_in);
		bad_count++;
		give_verdict();
	end
	initial begin
		nrst_in = 1'b0;
		{auto_mode_in, ch1_change_enable_in, ch0_code_rd_in} = 3'b110;
		{ch1_code_rd_in, monitor_rx_irq_enable_in} = 2'b00;
		{monitor_ready_bit_control_in, monitor_irq_enable_in} = 2'b00;
		{monitor_status_rd_in, monitor_rx_ready_in} = 2'b00;
		{command_wr_in, main_rd_in, ext_rd_in} = 3'b000;
		{ch0_rx_code_in, ch1_rx_code_in} = 8'hff;
		{command_register_in, mask_in} = 16'h0000;
		rx_frame_bytes_in = 5'h13;
		if_mode_in = CME_IF_SECOND_TERMINAL;
		monitor_ev_in = '0;
		hdlc_ev_in = '0;
		do_reset();
		chk("codes", {ch0_code_reg_out, ch1_code_reg_out}, 8'hff);
		chk("flags", {monitor_receive_ack_bit_out, irq_n_out, ms[5:0]},
			8'hc0);
		foreach (ROWS[i]) begin
			if (ROWS[i].cmd != 8'h00)
				cmd_wr(ROWS[i].cmd);
			hev(ROWS[i].ev);
			chk("main", ms, ROWS[i].main);
			chk("ext", es, ROWS[i].ext);
			chk("irq low", {7'h00, irq_n_out}, 8'h00);
			if (ROWS[i].main[6])
				chk("count", {3'h0, rx_byte_count_low_out}, 8'h13);
			pulse(main_rd_in);
			chk("main kept", ms, ROWS[i].main & 8'h05);
			pulse(ext_rd_in);
			chk("all clear", ms | es, 8'h00);
			chk("irq high", {7'h00, irq_n_out}, 8'h01);
			cmd_wr(CMD_RX_COMPLETE);
		end
		ch0_rx_code_in = 4'h1;
		tick(2);
		chk("c0 new", {3'h0, ch0_code_changed_out, ch0_code_reg_out},
			8'h11);
		chk("cic", {6'h0, ms[MS_CIC], irq_n_out}, 8'h02);
		ch0_rx_code_in = 4'h2;
		tick(2);
		ch0_rx_code_in = 4'h3;
		tick(2);
		chk("c0 held", {4'h0, ch0_code_reg_out}, 8'h01);
		pulse(ch0_code_rd_in);
		tick(1);
		chk("c0 last", {3'h0, ch0_code_changed_out, ch0_code_reg_out},
			8'h13);
		pulse(ch0_code_rd_in);
		tick(1);
		chk("c0 clear", {6'h0, ch0_code_changed_out, ms[MS_CIC]}, 8'h00);
		ch1_change_enable_in = 1'b0;
		ch1_rx_code_in = 4'h5;
		tick(2);
		chk("c1 hidden", {7'h0, ch1_code_changed_out}, 8'h00);
		ch1_change_enable_in = 1'b1;
		tick(1);
		chk("c1 shown", {6'h0, ch1_code_changed_out, ms[MS_CIC]}, 8'h03);
		pulse(ch0_code_rd_in);
		tick(1);
		chk("c1 clear", {7'h0, ch1_code_changed_out}, 8'h00);
		if_mode_in = CME_IF_SECOND_NONTERM;
		ch1_rx_code_in = 4'h6;
		tick(2);
		chk("c1 nonterm", {6'h0, ch1_code_changed_out, ms[MS_CIC]}, 8'h00);
		ch1_rx_code_in = 4'h5;
		if_mode_in = CME_IF_SECOND_TERMINAL;
		mev();
		chk("mon gated", {5'h0, monitor_status_reg_out}, 8'h00);
		monitor_irq_enable_in = 1'b1;
		mev();
		chk("mon events", {5'h0, monitor_status_reg_out}, 8'h07);
		pulse(monitor_status_rd_in);
		i_l1.send(8'h20, 1);
		tick(1);
		chk("no rx flag", {7'h0, monitor_byte_received_out}, 8'h00);
		monitor_rx_irq_enable_in = 1'b1;
		// close the packet begun while disabled
		mev();
		i_l1.send(8'h30, 1);
		tick(1);
		chk("first byte", {7'h0, monitor_byte_received_out}, 8'h01);
		pulse(monitor_status_rd_in);
		i_l1.send(8'h31, 1);
		tick(1);
		chk("later byte", {7'h0, monitor_byte_received_out}, 8'h00);
		pulse(monitor_status_rd_in);
		if_mode_in = CME_IF_FIRST_GEN;
		pulse(main_rd_in);
		i_l1.send(8'h50, 1);
		tick(1);
		chk("mos direct", {7'h0, ms[MS_MOS]}, 8'h01);
		if_mode_in = CME_IF_SECOND_TERMINAL;
		// mid-run reset, then fill the fifo past its depth while stalled
		do_reset();
		monitor_ready_bit_control_in = 1'b1;
		i_l1.send(8'h60, 5);
		chk("ack refused", {7'h0, monitor_receive_ack_bit_out}, 8'h01);
		tick(1);
		for (int i = 0; i < 4; i++) begin
			chk("rx valid", {7'h0, monitor_rx_valid_out}, 8'h01);
			chk("rx data", monitor_rx_data_out, 8'h60 + 8'(i));
			pulse(monitor_rx_ready_in);
		end
		chk("rx empty", {7'h0, monitor_rx_valid_out}, 8'h00);
		pulse(monitor_status_rd_in);
		mask_in = 8'h10;
		hev(9'h010);
		chk("masked", {7'h0, ms[MS_XPR]}, 8'h00);
		pulse(main_rd_in);
		mask_in = 8'h00;
		tick(1);
		chk("unmasked", {7'h0, ms[MS_XPR]}, 8'h01);
		pulse(main_rd_in);
		hev(9'h100);
		pulse(main_rd_in);
		hev(9'h100);
		chk("pool held", {7'h0, ms[MS_RPF]}, 8'h00);
		cmd_wr(CMD_RX_COMPLETE | CMD_TX_RESET);
		chk("pool next", {7'h0, ms[MS_RPF]}, 8'h01);
		chk("pool busy", {7'h0, rx_pool_busy_out}, 8'h01);
		auto_mode_in = 1'b0;
		hev(9'h020);
		chk("pce manual", es, 8'h00);
		give_verdict();
	end
endmodule // tb_cme_event_logic
